// ===== common/ebc_pkg.sv
package ebc_pkg;
    localparam int ADDR_W      = 16;
    localparam int NUM_SEL     = 4;
    localparam int SYNC_STAGES = 2;
    localparam logic [0:0] OE_DRIVE   = 1'h0;
    localparam logic [0:0] OE_RELEASE = 1'h1;
    localparam logic [0:0] STROBE_IDLE = 1'h1;
    localparam logic [0:0] STROBE_ACT  = 1'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    typedef enum logic [1:0] {
        EBC_RESET,
        EBC_OWNED,
        EBC_GRANTED
    } ebc_bus_state_t;
endpackage

// ===== hw/ebc_region_decode.sv
`timescale 1ns/10ps
`default_nettype none
module ebc_region_decode
    import ebc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int NS = NUM_SEL
) (
    input  wire logic [AW-1:0]    addr,
    input  wire logic             mem_n,
    input  wire logic             io_n,
    input  wire logic [NS*AW-1:0] lo_bound,
    input  wire logic [NS*AW-1:0] hi_bound,
    input  wire logic [NS-1:0]    is_io,
    output logic      [NS-1:0]    hit
);
    ////////////////////////////////////////////////////////////////////////
    // lowest index wins on overlap, like a fixed-priority decoder
    always_comb begin
        logic taken;
        taken = 1'h0;
        hit   = '0;
        for (int i = 0; i < NS; i++) begin
            if (!taken
                && ((is_io[i] && !io_n) || (!is_io[i] && !mem_n))  // R4
                && addr >= lo_bound[i*AW +: AW]
                && addr <= hi_bound[i*AW +: AW]) begin  // R7
                hit[i] = 1'h1;
                taken  = 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/ebc_bus_pins.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: memory request low on memory access
// R2: memory request released in reset, input when granted
// R3: write strobe low on processor write
// R4: memory or I/O space chosen by request pins
// R5: write strobe tristated whole grant
// R6: read strobe low on read, tristated when granted
// R7: four region selects from configured ranges
// R8: region selects still driven while granted
// R9: address pins driven in normal operation
// R10: address pins become inputs when granted
// R11: region selects decoded from pin address levels
module ebc_bus_pins
    import ebc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int NS = NUM_SEL
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             bus_grant,
    input  wire logic [AW-1:0]    cpu_addr,
    input  wire logic             cpu_mem,
    input  wire logic             cpu_io,
    input  wire logic             cpu_rd,
    input  wire logic             cpu_wr,
    input  wire logic             cpu_instr,
    input  wire logic [NS*AW-1:0] region_lo,
    input  wire logic [NS*AW-1:0] region_hi,
    input  wire logic [NS-1:0]    region_is_io,
    input  wire logic [AW-1:0]    addr_pin_i,
    input  wire logic             memory_request_n_i,
    input  wire logic             io_request_n_i,
    output logic      [AW-1:0]    addr_pin_o,
    output logic      [AW-1:0]    addr_pin_oe_n,
    output logic                  memory_request_n_o,
    output logic                  memory_request_n_oe_n,
    output logic                  io_request_n_o,
    output logic                  read_n_o,
    output logic                  read_n_oe_n,
    output logic                  write_n_o,
    output logic                  write_n_oe_n,
    output logic                  instruction_read_n,
    output logic      [NS-1:0]    region_select_n
);
    ////////////////////////////////////////////////////////////////////////
    // pin inputs synchronised; first stage read only by second
    logic [AW-1:0] addr_s1_reg,  addr_s2_reg;
    logic          memory_request_n_s1_reg,  memory_request_n_s2_reg;
    logic          ioreq_s1_reg, ioreq_s2_reg;
    logic          grant_s1_reg, grant_s2_reg;

    always_ff @(posedge clk) begin
        addr_s1_reg  <= addr_pin_i;
        addr_s2_reg  <= addr_s1_reg;
        memory_request_n_s1_reg  <= memory_request_n_i;
        memory_request_n_s2_reg  <= memory_request_n_s1_reg;
        ioreq_s1_reg <= io_request_n_i;
        ioreq_s2_reg <= ioreq_s1_reg;
        grant_s1_reg <= bus_grant;
        grant_s2_reg <= grant_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // a grant already up as reset lifts skips ownership: no drive fight
    ebc_bus_state_t state_reg, state_next;

    always_comb begin
        case (state_reg)
            EBC_RESET:   state_next = grant_s2_reg ? EBC_GRANTED : EBC_OWNED;
            EBC_OWNED:   state_next = grant_s2_reg ? EBC_GRANTED : EBC_OWNED;
            EBC_GRANTED: state_next = grant_s2_reg ? EBC_GRANTED : EBC_OWNED;
            default:     state_next = EBC_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= EBC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    logic own_next;
    assign own_next = (state_next == EBC_OWNED);

    ////////////////////////////////////////////////////////////////////////
    // output enables; all released in reset and while granted
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_pin_oe_n         <= {AW{OE_RELEASE}};
            memory_request_n_oe_n <= OE_RELEASE;  // R2
            read_n_oe_n           <= OE_RELEASE;
            write_n_oe_n          <= OE_RELEASE;
        end else begin
            addr_pin_oe_n         <= {AW{~own_next}};  // R9 R10
            memory_request_n_oe_n <= ~own_next;  // R2
            read_n_oe_n           <= ~own_next;  // R6
            write_n_oe_n          <= ~own_next;  // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobes; held idle when not owned so a regain starts clean
    always_ff @(posedge clk) begin
        if (rst || !own_next) begin
            addr_pin_o         <= AW'(ADDR_RESET);
            memory_request_n_o <= STROBE_IDLE;
            io_request_n_o     <= STROBE_IDLE;
            read_n_o           <= STROBE_IDLE;
            write_n_o          <= STROBE_IDLE;
            instruction_read_n <= STROBE_IDLE;
        end else begin
            addr_pin_o         <= cpu_addr;  // R9
            memory_request_n_o <= ~cpu_mem;  // R1
            io_request_n_o     <= ~(cpu_io && !cpu_mem);  // R4
            read_n_o           <= ~(cpu_rd && (cpu_mem || cpu_io));  // R6
            write_n_o          <= ~(cpu_wr && (cpu_mem || cpu_io));  // R3
            instruction_read_n <= ~(cpu_instr && cpu_mem && cpu_rd);  // R1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode from pin levels: trades two cycles of lag for one source
    logic [NS-1:0] hit;

    ebc_region_decode #(.AW(AW), .NS(NS)) u_decode (
        .addr     (addr_s2_reg),   // R11
        .mem_n    (memory_request_n_s2_reg),
        .io_n     (ioreq_s2_reg),
        .lo_bound (region_lo),
        .hi_bound (region_hi),
        .is_io    (region_is_io),
        .hit      (hit)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            region_select_n <= {NS{STROBE_IDLE}};
        end else begin
            region_select_n <= ~hit;  // R7 R8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handover steps shared by the grant and regain checks
    sequence s_grant_seen;
        grant_s2_reg;
    endsequence

    sequence s_grant_gone;
        !grant_s2_reg;
    endsequence

    sequence s_pins_released;
        addr_pin_oe_n == '1 && memory_request_n_oe_n == OE_RELEASE
            && read_n_oe_n == OE_RELEASE && write_n_oe_n == OE_RELEASE;
    endsequence

    sequence s_pins_driven;
        addr_pin_oe_n == '0 && memory_request_n_oe_n == OE_DRIVE
            && read_n_oe_n == OE_DRIVE && write_n_oe_n == OE_DRIVE;
    endsequence

    sequence s_strobes_idle;
        read_n_o == STROBE_IDLE && write_n_o == STROBE_IDLE
            && memory_request_n_o == STROBE_IDLE;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_write_tristate: assert property (@(posedge clk) disable iff (rst)  // R5
        state_reg == EBC_GRANTED |-> write_n_oe_n == OE_RELEASE)
        else $error("write strobe driven while granted");

    a_read_tristate: assert property (@(posedge clk) disable iff (rst)  // R6
        state_reg == EBC_GRANTED |-> read_n_oe_n == OE_RELEASE)
        else $error("read strobe driven while granted");

    a_memory_request_n_released: assert property (@(posedge clk)  // R2
        rst |=> memory_request_n_oe_n == OE_RELEASE)
        else $error("memory request driven after reset");

    a_addr_driven: assert property (@(posedge clk) disable iff (rst)  // R9
        state_reg == EBC_OWNED |-> addr_pin_oe_n == '0)
        else $error("address not driven while owned");

    a_addr_input: assert property (@(posedge clk) disable iff (rst)  // R10
        state_reg == EBC_GRANTED |-> addr_pin_oe_n == '1)
        else $error("address driven while granted");

    a_memory_request_n_follow: assert property (@(posedge clk) disable iff (rst)  // R1
        (own_next && cpu_mem) |=> memory_request_n_o == STROBE_ACT)
        else $error("memory request missing");

    a_write_follow: assert property (@(posedge clk) disable iff (rst)  // R3
        (own_next && cpu_wr && cpu_mem) |=> write_n_o == STROBE_ACT)
        else $error("write strobe missing");

    a_select_onehot: assert property (@(posedge clk) disable iff (rst)  // R7
        $onehot0(~region_select_n))
        else $error("more than one region select");

    // reset cuts the decode pipe, so the first select after it is skipped
    a_select_pins: assert property (@(posedge clk) disable iff (rst)  // R8 R11
        !$past(rst) |-> region_select_n == ~$past(hit))
        else $error("region select not from pin decode");

    a_io_space: assert property (@(posedge clk) disable iff (rst)  // R4
        (own_next && cpu_mem) |=> io_request_n_o == STROBE_IDLE)
        else $error("both request pins active");

    a_grant_release: assert property (@(posedge clk) disable iff (rst)  // R10
        s_grant_seen |=> s_pins_released)
        else $error("pins still driven after grant seen");

    a_regain_drive: assert property (@(posedge clk) disable iff (rst)  // R9
        s_grant_gone |=> s_pins_driven)
        else $error("pins not driven once grant is gone");

    a_grant_idle: assert property (@(posedge clk) disable iff (rst)  // R5 R6
        s_grant_seen |=> s_strobes_idle)
        else $error("strobes active while granted");

    a_reset_idle: assert property (@(posedge clk)  // R2
        rst |=> s_strobes_idle)
        else $error("strobes active after reset");
endmodule
`default_nettype wire

// ===== sim/ebc_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module ebc_far_side
    import ebc_pkg::*;
(
    input  wire logic              master_on,
    input  wire logic [ADDR_W-1:0] m_addr,
    input  wire logic [ADDR_W-1:0] a_o,
    input  wire logic [ADDR_W-1:0] a_oe,
    input  wire logic              mq_o,
    input  wire logic              mq_oe,
    output logic      [ADDR_W-1:0] a_pin,
    output logic                   mq_pin
);
    // released bits with no master show the inverse, so stale values fail
    assign a_pin = (a_o & ~a_oe) | ((master_on ? m_addr : ~a_o) & a_oe);
    // request line has a pull-up; the master requests memory while it owns
    assign mq_pin = mq_oe ? !master_on : mq_o;
endmodule
`default_nettype wire

// ===== sim/test_external_bus_pin_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_external_bus_pin_control;
    import ebc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, grant = 1'b0, mst = 1'b0;
    logic mem = 1'b0, io = 1'b0, rd = 1'b0, wr = 1'b0, ins = 1'b0;
    logic [ADDR_W-1:0] ca = 16'h0000, ma = 16'h0000, a_o, a_oe, a_pin;
    logic mq_o, mq_oe, mq_pin, io_o, rd_o, rd_oe, wr_o, wr_oe, irn;
    logic [NUM_SEL-1:0] sel;
    int err_count = 0, checks = 0, cyc = 0;
    always #10 clk = ~clk;
    ebc_bus_pins ebc_bus_pins_i (.clk(clk), .rst(rst), .bus_grant(grant),
        .cpu_addr(ca), .cpu_mem(mem), .cpu_io(io), .cpu_rd(rd),
        .cpu_wr(wr), .cpu_instr(ins),
        .region_lo({16'h8000, 16'h0080, 16'h4000, 16'h0000}),
        .region_hi({16'hFFFF, 16'h00FF, 16'h4FFF, 16'h0FFF}),
        .region_is_io(4'h4), .addr_pin_i(a_pin),
        .memory_request_n_i(mq_pin), .io_request_n_i(io_o),
        .addr_pin_o(a_o), .addr_pin_oe_n(a_oe),
        .memory_request_n_o(mq_o), .memory_request_n_oe_n(mq_oe),
        .io_request_n_o(io_o), .read_n_o(rd_o), .read_n_oe_n(rd_oe),
        .write_n_o(wr_o), .write_n_oe_n(wr_oe),
        .instruction_read_n(irn), .region_select_n(sel));
    ebc_far_side ebc_far_side_i (.master_on(mst), .m_addr(ma), .a_o(a_o),
        .a_oe(a_oe), .mq_o(mq_o), .mq_oe(mq_oe), .a_pin(a_pin),
        .mq_pin(mq_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // step off the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_mem_read;
        @(posedge clk);
        {mem, rd, ins} <= 3'h7;
        ca <= 16'h0123;
        tick(1);
        check("addr", a_o, 16'h0123);
        check("strobes", {mq_o, rd_o, wr_o, irn}, 4'h2);
        check("drive", {a_oe, mq_oe, rd_oe, wr_oe}, 19'h0);
        tick(3);
        check("mem select", sel, 4'hE);
        @(posedge clk);
        {mem, rd, ins} <= 3'h0;
        $display("test mem read done");
    endtask
    task automatic test_io_write;
        @(posedge clk);
        {io, wr} <= 2'h3;
        ca <= 16'h0090;
        tick(1);
        check("io strobes", {io_o, mq_o, rd_o, wr_o}, 4'h6);
        tick(3);
        check("io select", sel, 4'hB);
        @(posedge clk);
        {io, wr} <= 2'h0;
        $display("test io write done");
    endtask
    task automatic test_grant;
        @(posedge clk);
        {grant, mst, mem, rd} <= 4'hF;
        ma <= 16'h4321;
        tick(3);
        check("grant oe", {a_oe, mq_oe, rd_oe, wr_oe}, 19'h7FFFF);
        check("grant strobes", {rd_o, wr_o}, 2'h3);
        tick(3);
        check("master select", sel, 4'hD);
        @(posedge clk);
        {grant, mst, mem, rd} <= 4'h0;
        tick(3);
        check("regain oe", {a_oe, mq_oe, rd_oe, wr_oe}, 19'h0);
        $display("test grant done");
    endtask
    task automatic test_mem_write;
        @(posedge clk);
        {mem, wr} <= 2'h3;
        ca <= 16'h9ABC;
        tick(1);
        check("write addr", a_o, 16'h9ABC);
        check("write strobes", {mq_o, io_o, rd_o, wr_o, irn}, 5'h0D);
        tick(3);
        check("high select", sel, 4'h7);
        @(posedge clk);
        {mem, wr} <= 2'h0;
        $display("test mem write done");
    endtask
    // grant held through a reset: pins must stay released as it lifts
    task automatic test_reset_grant;
        @(posedge clk);
        {rst, grant, mst} <= 3'h7;
        ma <= 16'h0040;
        tick(4);
        check("reset oe", {a_oe, mq_oe, rd_oe, wr_oe}, 19'h7FFFF);
        @(posedge clk);
        rst <= 1'b0;
        tick(1);
        check("lift oe", {a_oe, mq_oe, rd_oe, wr_oe}, 19'h7FFFF);
        check("lift strobes", {mq_o, rd_o, wr_o}, 3'h7);
        check("lift select", sel, 4'hE);
        @(posedge clk);
        {grant, mst} <= 2'h0;
        tick(3);
        check("owned oe", {a_oe, mq_oe, rd_oe, wr_oe}, 19'h0);
        $display("test reset grant done");
    endtask
    // ceiling well above the few dozen cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        tick(2);
        check("reset", {a_oe, mq_oe, rd_oe, wr_oe, sel}, 23'h7FFFFF);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        test_mem_read();
        test_io_write();
        test_mem_write();
        test_grant();
        test_reset_grant();
        print_verdict();
    end
endmodule
`default_nettype wire
